// ### samc_pkg.sv
// Package for the sleep and airplane mode controller.
// Assumes a single core clock domain and a plain register port.
package samc_pkg;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FUNC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;

  // Control register bit positions.
  localparam int CTRL_SLEEP_EN = 0;
  localparam int CTRL_USB_HOST = 1;
  localparam int CTRL_REMOTE_WK = 2;
  localparam int CTRL_HS_POL = 3;
  localparam int CTRL_AIR_PIN_EN = 4;
  localparam int CTRL_POWER_DOWN = 5;
  localparam int CTRL_REPORT = 6;
  localparam int CTRL_USB_DATA = 7;
  localparam int CTRL_USB_SUSP = 8;

  // Functionality levels.
  localparam logic [2:0] FUN_MIN = 3'h0;
  localparam logic [2:0] FUN_FULL = 3'h1;
  localparam logic [2:0] FUN_AIR = 3'h4;

  // Reset values.
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [2:0] FUNC_RESET = FUN_FULL;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // Interrupt bit positions.
  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_BADFUN = 3;

  // Wake pulse lengths.
  localparam int RI_PULSE_NS = 120;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RI_PULSE_CYC = (RI_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SAMC_AWAKE = 2'b00,
    SAMC_SLEEP = 2'b01,
    SAMC_DOWN = 2'b10
  } samc_state_e;

  typedef struct packed {
    logic dtr;
    logic radio_off_n;
    logic host_sleep_sense;
    logic bus_power_sense;
  } samc_pins_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } samc_bus_s;

endpackage

// ### samc_ctrl.sv
// Sleep, wake and airplane mode controller for a cellular modem core.
// Assumes asynchronous host pins that are synchronised here and one clock.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module samc_ctrl #(
  // RI pulse length in core clock cycles.
  parameter int RI_CYC = samc_pkg::RI_PULSE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire samc_pkg::samc_bus_s bus,
  output logic [31:0] rdata,
  // Host pins
  input wire samc_pkg::samc_pins_s pins,
  // Power and function outputs
  output logic asleep,
  output logic ri_out,
  output logic usb_remote_wake,
  output logic rf_enable,
  output logic sim_enable,
  output logic gnss_enable,
  output logic serial_enable,
  output logic sw_active,
  output logic rx_enable,
  output logic cmd_reject,
  output logic irq
);
  import samc_pkg::*;

  // The pulse checker below watches eight cycles and the counter holds eight bits.
  if (RI_CYC < 8 || RI_CYC > 255) begin : g_bad_ri_cyc
    $error("RI_CYC must lie between 8 and 255");
  end

  samc_pins_s sync1;
  samc_pins_s sync2;
  logic [8:0] ctrl;
  logic [2:0] func;
  logic [3:0] irq_stat;
  logic [3:0] irq_en;
  samc_state_e state;
  samc_state_e next_state;
  logic [7:0] ri_cnt;
  logic host_asleep;
  logic airplane;
  logic enter_ok;
  logic wake_req;
  logic report_pend;
  logic report_q;
  logic ev_sleep;
  logic ev_wake;
  logic ev_reject;
  logic ev_badfun;
  logic wr_cmd;
  logic cmd_is_rf;
  logic wr_func;
  logic func_ok;
  logic bus_power_q;
  logic ri_want;
  logic [1:0] warm_cnt;

  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  // Previous synchronised bus power level, so that a restore is seen as an edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_power_q <= 1'b0;
    end else begin
      bus_power_q <= sync2.bus_power_sense;
    end
  end

  // Host sleep polarity: bit set means a high level marks the host asleep.
  assign host_asleep = ctrl[CTRL_HS_POL] ? sync2.host_sleep_sense : ~sync2.host_sleep_sense;

  // The pin only counts once software enabled it, so a floating pin at boot is harmless.
  assign airplane = (func != FUN_FULL) || (ctrl[CTRL_AIR_PIN_EN] && !sync2.radio_off_n);

  // Register writes.
  assign wr_func = bus.wr && (bus.addr == REG_FUNC);
  assign func_ok = (bus.wdata[2:0] == FUN_MIN) || (bus.wdata[2:0] == FUN_FULL) || (bus.wdata[2:0] == FUN_AIR);
  assign wr_cmd = bus.wr && (bus.addr == REG_CMD);
  assign cmd_is_rf = bus.wdata[0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (bus.wr && bus.addr == REG_CTRL) begin
      ctrl <= bus.wdata[8:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      func <= FUNC_RESET;
    end else if (wr_func && func_ok) begin
      func <= bus.wdata[2:0];
    end
  end

  // Sleep entry and wake conditions.
  always_comb begin
    if (ctrl[CTRL_USB_HOST]) begin
      enter_ok = ctrl[CTRL_SLEEP_EN] && sync2.dtr && (ctrl[CTRL_USB_SUSP] || !sync2.bus_power_sense);
    end else begin
      enter_ok = ctrl[CTRL_SLEEP_EN] && sync2.dtr;
    end
  end

  assign wake_req = !sync2.dtr
                 || (ctrl[CTRL_USB_HOST] && ctrl[CTRL_USB_DATA])
                 || (sync2.bus_power_sense && !bus_power_q)
                 || !ctrl[CTRL_SLEEP_EN];
  assign report_pend = ctrl[CTRL_REPORT];

  always_comb begin
    next_state = state;
    case (state)
      SAMC_AWAKE: begin
        if (ctrl[CTRL_POWER_DOWN]) begin
          next_state = SAMC_DOWN;
        end else if (enter_ok && !wake_req) begin
          next_state = SAMC_SLEEP;
        end
      end
      SAMC_SLEEP: begin
        if (ctrl[CTRL_POWER_DOWN]) begin
          next_state = SAMC_DOWN;
        end else if (wake_req || !enter_ok) begin
          next_state = SAMC_AWAKE;
        end
      end
      SAMC_DOWN: begin
        if (!ctrl[CTRL_POWER_DOWN]) begin
          next_state = SAMC_AWAKE;
        end
      end
      default: next_state = SAMC_AWAKE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SAMC_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  // Host wakeup. Unless USB remote wakeup is on, RI fires when a pending report and a sleeping host first coincide, so a report
  // raised while the host is still awake rings once the host drops into sleep.
  assign ri_want = report_pend && host_asleep && !(ctrl[CTRL_USB_HOST] && ctrl[CTRL_REMOTE_WK]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      report_q <= 1'b0;
      ri_cnt <= 8'h00;
      ri_out <= 1'b0;
      usb_remote_wake <= 1'b0;
    end else begin
      report_q <= ri_want;
      if (ri_want && !report_q) begin
        ri_cnt <= 8'(RI_CYC);
      end else if (ri_cnt != 8'h00) begin
        ri_cnt <= ri_cnt - 8'h01;
      end
      ri_out <= (ri_cnt != 8'h00);
      usb_remote_wake <= report_pend && host_asleep && ctrl[CTRL_USB_HOST] && ctrl[CTRL_REMOTE_WK];
    end
  end

  // Function outputs.
  // Positioning ignores the function level and only drops in power-down.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_enable <= 1'b1;
      sim_enable <= 1'b1;
      gnss_enable <= 1'b1;
      serial_enable <= 1'b1;
      sw_active <= 1'b1;
      rx_enable <= 1'b1;
      asleep <= 1'b0;
    end else begin
      rf_enable <= !airplane && (state != SAMC_DOWN);
      sim_enable <= (func != FUN_MIN) && (state != SAMC_DOWN);
      gnss_enable <= (state != SAMC_DOWN);
      serial_enable <= (state != SAMC_DOWN);
      sw_active <= (state != SAMC_DOWN);
      rx_enable <= (state != SAMC_DOWN) && !airplane;
      asleep <= (state == SAMC_SLEEP);
    end
  end

  // The reject pulse tells the command layer to drop the RF command.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= wr_cmd && cmd_is_rf && airplane;
    end
  end

  // Interrupts: set wins over clear.
  assign ev_sleep = (state == SAMC_AWAKE) && (next_state == SAMC_SLEEP);
  assign ev_wake = (state == SAMC_SLEEP) && (next_state == SAMC_AWAKE);
  assign ev_reject = wr_cmd && cmd_is_rf && airplane;
  assign ev_badfun = wr_func && !func_ok;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~((bus.wr && bus.addr == REG_IRQ_CLR) ? bus.wdata[3:0] : 4'h0))
                  | {ev_badfun, ev_reject, ev_wake, ev_sleep};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= IRQ_RESET;
    end else if (bus.wr && bus.addr == REG_IRQ_EN) begin
      irq_en <= bus.wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  // Register reads, answered one cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      case (bus.addr)
        REG_CTRL: rdata <= {23'h0, ctrl};
        REG_FUNC: rdata <= {29'h0, func};
        REG_STATUS: rdata <= {26'h0, airplane, host_asleep, sync2.bus_power_sense, sync2.dtr, state};
        REG_IRQ_STAT: rdata <= {28'h0000000, irq_stat};
        REG_IRQ_EN: rdata <= {28'h0000000, irq_en};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Assertions.
  // The synchroniser check waits until three samples after reset exist, since the past values
  // would otherwise be pin levels taken while the flops were still held in reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_cnt <= 2'h0;
    end else if (warm_cnt != 2'h3) begin
      warm_cnt <= warm_cnt + 2'h1;
    end
  end

  sequence s_report_rise;
    ri_want && !report_q;
  endsequence

  chk_sync_stage: assert property (@(posedge core_clk) disable iff (!rst_n)
    (warm_cnt == 2'h3) |-> sync2 == $past(pins, 2)) else $error("synchroniser depth wrong");
  chk_uart_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_AWAKE && next_state == SAMC_SLEEP && !ctrl[CTRL_USB_HOST]) |-> (ctrl[CTRL_SLEEP_EN] && sync2.dtr))
    else $error("uart sleep entry without conditions");
  chk_dtr_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_SLEEP && !sync2.dtr && !ctrl[CTRL_POWER_DOWN]) |=> state == SAMC_AWAKE)
    else $error("dtr low did not wake");
  chk_ri_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_report_rise |-> ##2 ri_out [*8]) else $error("ri pulse missing");
  chk_usb_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_AWAKE && next_state == SAMC_SLEEP && ctrl[CTRL_USB_HOST])
    |-> (sync2.dtr && ctrl[CTRL_SLEEP_EN] && (ctrl[CTRL_USB_SUSP] || !sync2.bus_power_sense)))
    else $error("usb sleep entry without conditions");
  chk_remote_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (report_pend && host_asleep && ctrl[CTRL_USB_HOST] && ctrl[CTRL_REMOTE_WK]) |=> usb_remote_wake)
    else $error("remote wakeup missing");
  chk_air_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!ctrl[CTRL_AIR_PIN_EN] && func == FUN_FULL && state != SAMC_DOWN) |=> rf_enable)
    else $error("radio pin acted while disabled");
  chk_func_legal: assert property (@(posedge core_clk) disable iff (!rst_n)
    func == FUN_MIN || func == FUN_FULL || func == FUN_AIR) else $error("illegal function level");
  chk_rf_reject: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_cmd && cmd_is_rf && airplane) |=> cmd_reject) else $error("rf command not rejected");
  chk_no_lost_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_AWAKE && wake_req) |=> state != SAMC_SLEEP) else $error("wake lost to sleep entry");

  // Each wake path except a cleared sleep enable is checked on its own, so a broken term shows up by name.
  chk_usb_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_SLEEP && ctrl[CTRL_USB_HOST] && ctrl[CTRL_USB_DATA] && !ctrl[CTRL_POWER_DOWN])
    |=> state == SAMC_AWAKE)
    else $error("usb data did not wake");
  chk_vbus_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_SLEEP && sync2.bus_power_sense && !bus_power_q && !ctrl[CTRL_POWER_DOWN])
    |=> state == SAMC_AWAKE)
    else $error("bus power restore did not wake");
  chk_ri_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctrl[CTRL_USB_HOST] && ctrl[CTRL_REMOTE_WK] && ri_cnt == 8'h00) |=> ri_cnt == 8'h00)
    else $error("ri started with remote wakeup");

  // Function level and airplane effects on the radio side.
  chk_air_rf: assert property (@(posedge core_clk) disable iff (!rst_n)
    airplane |=> (!rf_enable && !rx_enable))
    else $error("rf left on in airplane mode");
  chk_min_func: assert property (@(posedge core_clk) disable iff (!rst_n)
    (func == FUN_MIN) |=> (!sim_enable && !rf_enable))
    else $error("minimum level left sim or rf on");
  chk_badfun_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    ev_badfun |=> irq_stat[IRQ_BADFUN])
    else $error("bad level flag lost");
  chk_gnss_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_func && state != SAMC_DOWN) |=> gnss_enable)
    else $error("level change touched positioning");
  chk_reject_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    ev_reject |=> irq_stat[IRQ_REJECT])
    else $error("reject flag lost");

  // Power states, interrupt plumbing and idle read data.
  chk_down_closed: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_DOWN) |=> (!serial_enable && !sw_active))
    else $error("serial or software alive in power-down");
  chk_sleep_rx: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SAMC_SLEEP && !airplane) |=> (rx_enable && asleep))
    else $error("reception stopped in sleep");
  chk_wake_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    ev_wake |=> irq_stat[IRQ_WAKE])
    else $error("wake flag lost");
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|(irq_stat & irq_en)) |=> irq)
    else $error("enabled status bit without interrupt");
  chk_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !bus.rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read answer");

endmodule // samc_ctrl

// ### samc_host_model.sv
// Host processor model standing on the far side of the controller pins.
// Assumes the bench sets host intent levels right after a clock edge.
`timescale 1ns/1ps
module samc_host_model (
  // Clock
  input wire logic core_clk,
  // Host intent from the bench
  input wire logic dtr_lvl,
  input wire logic radio_drive,
  input wire logic host_asleep,
  input wire logic hs_pol,
  input wire logic vbus_on,
  // Device facing signals
  input wire logic ri_out,
  output samc_pkg::samc_pins_s pins,
  output int ri_n,
  output int ri_len
);
  import samc_pkg::*;
  int run;
  // A released radio-disable line floats up to its pull-up level. Without suspend support
  // the host cuts bus power by a switch. One assignment drives the whole pin bundle.
  assign pins = '{dtr: dtr_lvl,
                  radio_off_n: radio_drive ? 1'b0 : 1'b1,
                  host_sleep_sense: hs_pol ? host_asleep : ~host_asleep,
                  bus_power_sense: vbus_on};
  // RI lands on a wake-capable input that counts pulses and lengths.
  always @(posedge core_clk) begin
    if (ri_out === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      ri_len <= run;
      ri_n <= ri_n + 1;
      run <= 0;
    end
  end
endmodule // samc_host_model

// ### tb_top.sv
// Self-checking bench for the sleep and airplane mode controller.
// Assumes the host model drives the pins and the bench owns the bus.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
  end \
end
module tb_top;
  import samc_pkg::*;
  logic core_clk = 0, rst_n = 0, dtr = 0, rdrv = 0, hsl = 0, pol = 1, vb = 1;
  samc_bus_s bus = '0;
  samc_pins_s pins;
  logic [31:0] rdata;
  logic asleep, ri_out, usb_rw, rf, sim, gnss, ser, sw, rx, rej, irq;
  int fail_count, tests_run, rej_n, ri_n, ri_len, n0;
  logic [2:0] lv [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  logic [2:0] fx [4] = '{3'h0, 3'h4, 3'h4, 3'h1};
  logic [1:0] rs [4] = '{2'h0, 2'h1, 2'h1, 2'h3};
  samc_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .pins(pins),
    .asleep(asleep), .ri_out(ri_out), .usb_remote_wake(usb_rw), .rf_enable(rf), .sim_enable(sim),
    .gnss_enable(gnss), .serial_enable(ser), .sw_active(sw), .rx_enable(rx), .cmd_reject(rej), .irq(irq));
  samc_host_model host_u (.core_clk(core_clk), .dtr_lvl(dtr), .radio_drive(rdrv), .host_asleep(hsl),
    .hs_pol(pol), .vbus_on(vb), .ri_out(ri_out), .pins(pins), .ri_n(ri_n), .ri_len(ri_len));
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (rej === 1'b1) rej_n++;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    `CHK(nm, ex, rdata & m)
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // The whole sequence needs well under two thousand cycles.
  initial begin
    #(5 * 20000);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(2);
    `CHK("enables", 6'h3F, {rf, sim, gnss, ser, sw, rx})
    rdc("func", REG_FUNC, 32'hFFFFFFFF, 32'h1);
    rdc("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc("hole", 8'h40, 32'hFFFFFFFF, 32'h0);
    wr(REG_CTRL, 32'h1);
    cyc(5);
    `CHK("asleep", 1'b0, asleep)
    @(posedge core_clk) dtr <= 1'b1;
    cyc(2);
    `CHK("asleep", 1'b0, asleep)
    cyc(4);
    `CHK("asleep", 1'b1, asleep)
    `CHK("rx", 1'b1, rx)
    rdc("state", REG_STATUS, 32'h3, 32'h1);
    @(posedge core_clk) hsl <= 1'b1;
    wr(REG_CTRL, 32'h049);
    cyc(60);
    `CHK("ri", 1'b1, ri_n > 0)
    `CHK("ri len", RI_PULSE_CYC, ri_len)
    // Low polarity: the host reads as awake until its level drops.
    @(posedge core_clk) pol <= 1'b0;
    hsl <= 1'b0;
    wr(REG_CTRL, 32'h001);
    cyc(40);
    n0 = ri_n;
    wr(REG_CTRL, 32'h041);
    cyc(40);
    `CHK("ri idle", n0, ri_n)
    @(posedge core_clk) hsl <= 1'b1;
    cyc(60);
    `CHK("ri low pol", 1'b1, ri_n > n0)
    wr(REG_CTRL, 32'h001);
    @(posedge core_clk) dtr <= 1'b0;
    cyc(6);
    `CHK("asleep", 1'b0, asleep)
    @(posedge core_clk) dtr <= 1'b1;
    pol <= 1'b1;
    wr(REG_CTRL, 32'h003);
    cyc(6);
    `CHK("asleep", 1'b0, asleep)
    wr(REG_CTRL, 32'h103);
    cyc(6);
    `CHK("asleep", 1'b1, asleep)
    n0 = ri_n;
    wr(REG_CTRL, 32'h14F);
    cyc(10);
    `CHK("usb wake", 1'b1, usb_rw)
    `CHK("ri none", n0, ri_n)
    // Same report without remote wakeup support: RI must ring instead.
    wr(REG_CTRL, 32'h14B);
    cyc(60);
    `CHK("ri usb", 1'b1, ri_n > n0)
    `CHK("usb wake off", 1'b0, usb_rw)
    wr(REG_CTRL, 32'h18B);
    cyc(5);
    `CHK("asleep", 1'b0, asleep)
    wr(REG_CTRL, 32'h003);
    @(posedge core_clk) vb <= 1'b0;
    cyc(6);
    `CHK("asleep", 1'b1, asleep)
    @(posedge core_clk) vb <= 1'b1;
    cyc(6);
    `CHK("asleep", 1'b0, asleep)
    wr(REG_CTRL, 32'h0);
    @(posedge core_clk) rdrv <= 1'b1;
    cyc(6);
    `CHK("rf", 1'b1, rf)
    wr(REG_CTRL, 32'h010);
    cyc(6);
    `CHK("rf", 1'b0, rf)
    rdc("air", REG_STATUS, 32'h20, 32'h20);
    wr(REG_CMD, 32'h1);
    cyc(3);
    `CHK("rejects", 1, rej_n)
    rdc("rej bit", REG_IRQ_STAT, 32'h4, 32'h4);
    @(posedge core_clk) rdrv <= 1'b0;
    cyc(6);
    `CHK("rf", 1'b1, rf)
    wr(REG_CMD, 32'h1);
    cyc(3);
    `CHK("rejects", 1, rej_n)
    for (int i = 0; i < 4; i++) begin
      wr(REG_FUNC, {29'h0, lv[i]});
      cyc(3);
      `CHK("rf sim", rs[i], {rf, sim})
      `CHK("gnss", 1'b1, gnss)
      rdc("func", REG_FUNC, 32'h7, {29'h0, fx[i]});
    end
    rdc("bad func", REG_IRQ_STAT, 32'h8, 32'h8);
    `CHK("irq masked", 1'b0, irq)
    wr(REG_IRQ_EN, 32'h8);
    cyc(3);
    `CHK("irq", 1'b1, irq)
    wr(REG_IRQ_CLR, 32'hF);
    cyc(3);
    `CHK("irq", 1'b0, irq)
    rdc("stat", REG_IRQ_STAT, 32'hF, 32'h0);
    wr(REG_CTRL, 32'h020);
    cyc(4);
    `CHK("ser sw", 2'h0, {ser, sw})
    rdc("state", REG_STATUS, 32'h3, 32'h2);
    conclude();
  end
endmodule // tb_top
